// >>> core/srsl_fifo.sv
// small fifo with registered output stage
`timescale 1ns/1ps
`default_nettype none
module srsl_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  // depth must be a power of two
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    logic         ov;
    logic [W-1:0] od;
  } srsl_fifo_st_t;

  srsl_fifo_st_t r_reg;
  srsl_fifo_st_t r_next;
  logic [W-1:0]  mem [DEPTH];
  logic          empty;
  logic          full;
  logic          push;
  logic          pop;

  assign empty     = (r_reg.wp == r_reg.rp);
  assign full      = (r_reg.wp[AW] != r_reg.rp[AW]) && (r_reg.wp[AW-1:0] == r_reg.rp[AW-1:0]);
  assign in_ready  = ~full;
  assign push      = in_valid & ~full;
  assign pop       = ~empty & (~r_reg.ov | out_ready);
  assign out_valid = r_reg.ov;
  assign out_data  = r_reg.od;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wp = r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 1'b1;
      r_next.ov = 1'b1;
      r_next.od = mem[r_reg.rp[AW-1:0]];
    end else if (out_ready) begin
      r_next.ov = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[r_reg.wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule
`default_nettype wire

// >>> core/srsl_pkg.sv
// shared constants and types for the two-wire register access slave
package srsl_pkg;
  localparam logic [6:0] SRSL_SLAVE_ADDR = 7'h28;
  localparam logic [7:0] SRSL_PTR_RESET  = 8'h00;
  localparam int         SRSL_CLK_HZ     = 40_000_000;
  localparam int         SRSL_T_LOW_MS   = 30;
  localparam int         SRSL_T_IDLE_US  = 200;
  localparam int         SRSL_LOW_CYC    = SRSL_T_LOW_MS * (SRSL_CLK_HZ / 1000);
  localparam int         SRSL_IDLE_CYC   = SRSL_T_IDLE_US * (SRSL_CLK_HZ / 1_000_000);
  localparam int         SRSL_TMO_W      = 21;
  localparam int         SRSL_FIFO_DEPTH = 16;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_RACK = 5'b10000
  } srsl_state_t;

  typedef enum logic [1:0] {
    K_ADDR  = 2'h0,
    K_INDEX = 2'h1,
    K_DATA  = 2'h2
  } srsl_kind_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } srsl_wr_t;

  typedef struct packed {
    logic tog;
    logic bit_val;
  } srsl_link_t;
endpackage

// >>> core/srsl_slave.sv
// two-wire slave giving byte access to an 8-bit register space
// How it works
// - write: address 0101_000 with write bit, index, data, stop; all three bytes acked, the data byte only while the write buffer has room
// - read: index, repeated start, address with read bit, one byte, host nack, stop
// - index byte followed by stop only loads the pointer, no register changes
// - read without index returns byte at pointer and leaves pointer unchanged
// - pointer-only write in deep sleep need not work; here it still works
// - read at pointer in deep sleep need not work; here it still works
// - each written data byte goes to next register, pointer increments, wraps ff to 00
// - indexed multi-byte read returns successive registers; host nacks the last byte
// - addressed in deep sleep wakes core without clearing sleep; sleeps again after stop
// - standby does not affect the slave; standby bit is cleared by a normal write
// - stop condition resets slave state, ready for next transaction
// - with timeout enabled, clock low for 30 ms resets the interface
// - with timeout enabled, both lines high over 200 us resets the protocol
// - clock line is never driven; stretching by others is tolerated
`timescale 1ns/1ps
`default_nettype none
module srsl_slave
  import srsl_pkg::*;
#(
  parameter int LOW_CYC  = srsl_pkg::SRSL_LOW_CYC,
  parameter int IDLE_CYC = srsl_pkg::SRSL_IDLE_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             scl_clk,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe,
  input  wire logic             timeout_enable,
  input  wire logic             deep_sleep_request,
  output logic                  core_wake,
  output logic                  wr_valid,
  output srsl_pkg::srsl_wr_t    wr_req,
  input  wire logic             wr_ready,
  output logic [7:0]            rd_addr,
  input  wire logic [7:0]       rd_data
);
  import srsl_pkg::*;

  typedef struct packed {
    logic [1:0]           tog_s;
    logic                 tog_seen;
    logic [2:0]           scl_s;
    logic [2:0]           sda_s;
    srsl_state_t          st;
    srsl_kind_t           kind;
    logic                 done;
    logic [2:0]           cnt;
    logic [7:0]           sh;
    logic [7:0]           tx;
    logic                 rw;
    logic                 ack_pend;
    logic                 idx_seen;
    logic                 host_ack;
    logic [7:0]           ptr;
    logic                 sda_lo;
    logic                 sda_oe;
    logic                 wake;
    logic                 push;
    srsl_wr_t             push_d;
    logic [SRSL_TMO_W-1:0] tlow;
    logic [SRSL_TMO_W-1:0] tidle;
  } srsl_core_t;

  srsl_core_t r_reg;
  srsl_core_t r_next;
  srsl_link_t lk_reg;
  srsl_link_t lk_next;
  logic       fifo_ready;
  logic       bit_ev;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       tmo;
  logic [7:0] rx_byte;

  // link side: sample data on each rising clock and flag it with a toggle
  always_comb begin
    lk_next         = lk_reg;
    lk_next.tog     = ~lk_reg.tog;
    lk_next.bit_val = sda_i;
  end

  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  // bit_val is stable for the whole high phase, long after the toggle settles
  assign bit_ev   = r_reg.tog_s[1] ^ r_reg.tog_seen;
  assign scl_fall = r_reg.scl_s[2] & ~r_reg.scl_s[1];
  assign start_ev = r_reg.scl_s[1] & r_reg.scl_s[2] & r_reg.sda_s[2] & ~r_reg.sda_s[1];
  assign stop_ev  = r_reg.scl_s[1] & r_reg.scl_s[2] & ~r_reg.sda_s[2] & r_reg.sda_s[1];
  assign rx_byte  = {r_reg.sh[6:0], lk_reg.bit_val};
  assign tmo      = timeout_enable &&
                    (r_reg.tlow == SRSL_TMO_W'(LOW_CYC) || r_reg.tidle == SRSL_TMO_W'(IDLE_CYC));

  always_comb begin
    r_next          = r_reg;
    r_next.tog_s    = {r_reg.tog_s[0], lk_reg.tog};
    r_next.tog_seen = r_reg.tog_s[1];
    r_next.scl_s    = {r_reg.scl_s[1], r_reg.scl_s[0], scl_clk};
    r_next.sda_s    = {r_reg.sda_s[1], r_reg.sda_s[0], sda_i};
    r_next.push     = 1'b0;
    // timeout counters saturate at their limit
    if (r_reg.scl_s[1] || !timeout_enable) begin
      r_next.tlow = '0;
    end else if (r_reg.tlow != SRSL_TMO_W'(LOW_CYC)) begin
      r_next.tlow = r_reg.tlow + 1'b1;
    end
    if (!(r_reg.scl_s[1] && r_reg.sda_s[1]) || !timeout_enable) begin
      r_next.tidle = '0;
    end else if (r_reg.tidle != SRSL_TMO_W'(IDLE_CYC)) begin
      r_next.tidle = r_reg.tidle + 1'b1;
    end
    unique case (r_reg.st)
      ST_IDLE: begin
        r_next.sda_oe = 1'b0;
      end
      ST_RX: begin
        if (bit_ev) begin
          r_next.sh  = rx_byte;
          r_next.cnt = r_reg.cnt + 3'h1;
          if (r_reg.cnt == 3'h7) begin
            r_next.done     = 1'b1;
            r_next.ack_pend = 1'b0;
            unique case (r_reg.kind)
              K_ADDR: begin
                if (rx_byte[7:1] == SRSL_SLAVE_ADDR) begin
                  r_next.ack_pend = 1'b1;
                  r_next.rw       = rx_byte[0];
                  // waking leaves the sleep request itself untouched
                  if (deep_sleep_request) begin
                    r_next.wake = 1'b1;
                  end
                end
              end
              K_INDEX: begin
                // same path whether or not deep sleep is requested
                r_next.ptr      = rx_byte;
                r_next.idx_seen = 1'b1;
                r_next.ack_pend = 1'b1;
              end
              default: begin
                // a full buffer cannot stall the clock, so the byte is refused
                if (fifo_ready) begin
                  r_next.push     = 1'b1;
                  r_next.push_d   = '{addr: r_reg.ptr, data: rx_byte};
                  r_next.ptr      = r_reg.ptr + 8'h01;
                  r_next.ack_pend = 1'b1;
                end
              end
            endcase
          end
        end else if (scl_fall && r_reg.done) begin
          r_next.done = 1'b0;
          if (r_reg.ack_pend) begin
            r_next.st     = ST_ACK;
            r_next.sda_oe = 1'b1;
          end else begin
            r_next.st = ST_IDLE;
          end
        end
      end
      ST_ACK: begin
        if (scl_fall) begin
          if (r_reg.kind == K_ADDR && r_reg.rw) begin
            r_next.st     = ST_TX;
            r_next.tx     = rd_data;
            r_next.sda_oe = ~rd_data[7];
            r_next.cnt    = 3'h0;
          end else begin
            r_next.st     = ST_RX;
            r_next.sda_oe = 1'b0;
            r_next.cnt    = 3'h0;
            r_next.kind   = (r_reg.kind == K_ADDR) ? K_INDEX : K_DATA;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          r_next.cnt = r_reg.cnt + 3'h1;
          if (r_reg.cnt == 3'h7) begin
            r_next.st       = ST_RACK;
            r_next.sda_oe   = 1'b0;
            r_next.host_ack = 1'b0;
            // pointer only advances when this transaction set it
            if (r_reg.idx_seen) begin
              r_next.ptr = r_reg.ptr + 8'h01;
            end
          end else begin
            r_next.tx     = {r_reg.tx[6:0], 1'b0};
            r_next.sda_oe = ~r_reg.tx[6];
          end
        end
      end
      ST_RACK: begin
        if (bit_ev) begin
          r_next.host_ack = ~lk_reg.bit_val;
        end else if (scl_fall) begin
          if (r_reg.host_ack) begin
            r_next.st     = ST_TX;
            r_next.tx     = rd_data;
            r_next.sda_oe = ~rd_data[7];
            r_next.cnt    = 3'h0;
          end else begin
            r_next.st = ST_IDLE;
          end
        end
      end
    endcase
    if (stop_ev || tmo) begin
      r_next.st       = ST_IDLE;
      r_next.sda_oe   = 1'b0;
      r_next.done     = 1'b0;
      r_next.ack_pend = 1'b0;
      r_next.idx_seen = 1'b0;
      r_next.wake     = 1'b0;
    end
    // start wins over a saturated idle count, else every start after a long idle is lost
    if (start_ev) begin
      r_next.st       = ST_RX;
      r_next.kind     = K_ADDR;
      r_next.cnt      = 3'h0;
      r_next.done     = 1'b0;
      r_next.ack_pend = 1'b0;
      r_next.sda_oe   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg      <= '0;
      r_reg.st   <= ST_IDLE;
      r_reg.kind <= K_ADDR;
      r_reg.ptr  <= SRSL_PTR_RESET;
      r_reg.scl_s <= '1;
      r_reg.sda_s <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  srsl_fifo #(
    .W     ($bits(srsl_wr_t)),
    .DEPTH (SRSL_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (r_reg.push),
    .in_ready  (fifo_ready),
    .in_data   (r_reg.push_d),
    .out_valid (wr_valid),
    .out_data  (wr_req),
    .out_ready (wr_ready)
  );

  assign sda_o     = r_reg.sda_lo;
  assign sda_oe    = r_reg.sda_oe;
  assign core_wake = r_reg.wake;
  assign rd_addr   = r_reg.ptr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_drive: assert property (r_reg.st == ST_ACK |-> sda_oe)
    else $error("ack phase without data line low");
  a_tx_bit: assert property (r_reg.st == ST_TX |-> sda_oe == ~r_reg.tx[7])
    else $error("sent bit does not match shift register");
  a_ptr_index: assert property (r_reg.st == ST_RX && r_reg.kind == K_INDEX && bit_ev
      && r_reg.cnt == 3'h7 |=> rd_addr == $past(rx_byte))
    else $error("index byte did not load pointer");
  a_recv_keeps: assert property (r_reg.st == ST_TX && !r_reg.idx_seen |=> $stable(rd_addr))
    else $error("pointer moved during read at pointer");
  a_write_incr: assert property (r_reg.push |-> rd_addr == r_reg.push_d.addr + 8'h01)
    else $error("pointer not advanced after written byte");
  a_read_incr: assert property ($rose(r_reg.st == ST_RACK) && r_reg.idx_seen
      |-> rd_addr == $past(rd_addr) + 8'h01)
    else $error("pointer not advanced after read byte");
  a_wake_cause: assert property ($rose(core_wake) |-> $past(deep_sleep_request))
    else $error("wake without deep sleep request");
  a_stop_idle: assert property (stop_ev |=> r_reg.st == ST_IDLE && !sda_oe ##1 !core_wake)
    else $error("stop did not reset slave");
  a_low_tmo: assert property (timeout_enable && r_reg.tlow == SRSL_TMO_W'(LOW_CYC)
      |=> r_reg.st == ST_IDLE)
    else $error("clock low timeout missed");
  a_idle_tmo: assert property (timeout_enable && r_reg.tidle == SRSL_TMO_W'(IDLE_CYC)
      && !start_ev |=> r_reg.st == ST_IDLE)
    else $error("bus idle timeout missed");
  a_foreign_nack: assert property (r_reg.st == ST_RX && r_reg.kind == K_ADDR && bit_ev
      && r_reg.cnt == 3'h7 && rx_byte[7:1] != SRSL_SLAVE_ADDR |=> !r_reg.ack_pend)
    else $error("foreign address acknowledged");

  c_write_push: cover property (r_reg.push);
  c_read_two: cover property (r_reg.st == ST_RACK && r_reg.host_ack && scl_fall);
  c_timeout: cover property (tmo && r_reg.st != ST_IDLE);
  c_wake: cover property ($rose(core_wake));
endmodule
`default_nettype wire

// >>> tb/srsl_host.sv
// bus host model: drives the clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module srsl_host (
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  int t_low = 1600;
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // start or repeated start; the clock stands high between frames
  task automatic start();
    pull = 1'b0;
    #300 scl = 1'b1;
    #700 pull = 1'b1;
    #700 scl = 1'b0;
  endtask
  task automatic stop();
    #300 pull = 1'b1;
    #(t_low - 300) scl = 1'b1;
    #700 pull = 1'b0;
    #1400;
  endtask
  // eight bits msb first plus the ninth bit; a released line reads back
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    logic [8:0] sh;
    sh = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      #300 pull = ~sh[i];
      #(t_low - 300) scl = 1'b1;
      #500 sh[i] = sda;
      #500 scl = 1'b0;
    end
    rx = sh[8:1];
    ack_out = sh[0];
  endtask
  task automatic idle_high(input int ns);
    #300 pull = 1'b0;
    scl = 1'b1;
    #(ns) scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the two-wire register access slave
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srsl_pkg::*;
  localparam logic [7:0] AW = {SRSL_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] AR = {SRSL_SLAVE_ADDR, 1'b1};
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       tmo_en = 1'b0;
  logic       sleep = 1'b0;
  logic       wr_ready = 1'b0;
  logic       stall = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] regs [256];
  logic       scl, pull, sda_o, sda_oe, core_wake, wr_valid, ak;
  logic [7:0] rd_addr, rx;
  srsl_wr_t   wr_req;
  wire logic  sda = ~(sda_oe | pull);
  int         wr_cnt = 0;
  int         mismatches = 0;
  int         cmp_count = 0;

  srsl_slave #(.LOW_CYC(2000), .IDLE_CYC(200)) dut (
    .clk(clk), .rst_n(rst_n), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .timeout_enable(tmo_en), .deep_sleep_request(sleep),
    .core_wake(core_wake), .wr_valid(wr_valid), .wr_req(wr_req),
    .wr_ready(wr_ready), .rd_addr(rd_addr), .rd_data(rd_data));
  srsl_host host (.scl(scl), .pull(pull), .sda(sda));

  always #12.5 clk = ~clk;
  // register file stand-in
  always @(posedge clk) begin
    wr_ready <= ~stall;
    rd_data <= regs[rd_addr];
    if (wr_valid && wr_ready) begin
      regs[wr_req.addr] <= wr_req.data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic e);
    host.xfer(b, 1'b1, rx, ak);
    check(ak, e);
  endtask
  task automatic rb(input logic [7:0] e, input logic last);
    host.xfer(8'hff, last, rx, ak);
    check(rx, e);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic t_write_wrap();
    host.t_low = 5000;
    host.start();
    wb(AW, 1'b0);
    wb(8'hfe, 1'b0);
    wb(8'h5a, 1'b0);
    wb(8'hc3, 1'b0);
    wb(8'h3c, 1'b0);
    host.stop();
    host.t_low = 1600;
    repeat (20) @(posedge clk);
    check(regs[8'hfe], 8'h5a);
    check(regs[8'hff], 8'hc3);
    check(regs[8'h00], 8'h3c);
    check(core_wake, 1'b0);
    check(sda_o, 1'b0);
    $display("test write_wrap done");
  endtask
  task automatic t_read_block();
    host.start();
    wb(AW, 1'b0);
    wb(8'hfe, 1'b0);
    host.start();
    wb(AR, 1'b0);
    rb(8'h5a, 1'b0);
    rb(8'hc3, 1'b0);
    rb(8'h3c, 1'b1);
    host.stop();
    $display("test read_block done");
  endtask
  task automatic t_pointer();
    int n;
    n = wr_cnt;
    host.start();
    wb(AW, 1'b0);
    wb(8'hfe, 1'b0);
    host.stop();
    check(rd_addr, 8'hfe);
    for (int i = 0; i < 2; i++) begin
      host.start();
      wb(AR, 1'b0);
      rb(8'h5a, 1'b1);
      host.stop();
    end
    check(rd_addr, 8'hfe);
    check(8'(wr_cnt - n), 8'h00);
    $display("test pointer done");
  endtask
  task automatic t_foreign();
    int n;
    n = wr_cnt;
    host.start();
    wb(AW ^ 8'h02, 1'b1);
    wb(8'h10, 1'b1);
    host.stop();
    check(8'(wr_cnt - n), 8'h00);
    $display("test foreign done");
  endtask
  task automatic t_sleep();
    @(posedge clk) sleep <= 1'b1;
    host.start();
    wb(AW, 1'b0);
    check(core_wake, 1'b1);
    wb(8'h10, 1'b0);
    wb(8'h77, 1'b0);
    host.stop();
    repeat (10) @(posedge clk);
    check(core_wake, 1'b0);
    check(regs[8'h10], 8'h77);
    host.start();
    wb(AW, 1'b0);
    wb(8'h10, 1'b0);
    host.stop();
    check(rd_addr, 8'h10);
    host.start();
    wb(AR, 1'b0);
    rb(8'h77, 1'b1);
    host.stop();
    check(rd_addr, 8'h10);
    @(posedge clk) sleep <= 1'b0;
    $display("test sleep done");
  endtask
  task automatic t_timeouts();
    host.start();
    wb(AW, 1'b0);
    wb(8'h10, 1'b0);
    host.stop();
    @(posedge clk) tmo_en <= 1'b1;
    host.start();
    wb(AR, 1'b0);
    repeat (100) @(posedge clk);
    check(sda_oe, 1'b1);
    repeat (2000) @(posedge clk);
    check(sda_oe, 1'b0);
    host.stop();
    host.start();
    wb(AW, 1'b0);
    host.idle_high(300 * 25);
    wb(8'h10, 1'b1);
    check(rd_addr, 8'h10);
    host.stop();
    host.start();
    wb(AW, 1'b0);
    host.stop();
    @(posedge clk) tmo_en <= 1'b0;
    $display("test timeouts done");
  endtask
  task automatic t_fill();
    int n;
    n = wr_cnt + 17;
    @(posedge clk) stall <= 1'b1;
    host.start();
    wb(AW, 1'b0);
    wb(8'h40, 1'b0);
    for (int i = 0; i < 17; i++) begin
      wb(8'h80 + 8'(i), 1'b0);
    end
    wb(8'hee, 1'b1);
    host.stop();
    check(wr_valid, 1'b1);
    @(posedge clk) stall <= 1'b0;
    for (int i = 0; i < 200 && wr_cnt != n; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 17; i++) begin
      check(regs[8'h40 + 8'(i)], 8'h80 + 8'(i));
    end
    check(wr_valid, 1'b0);
    $display("test fill done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_write_wrap();
    t_read_block();
    t_pointer();
    t_foreign();
    t_sleep();
    t_timeouts();
    t_fill();
    tally_and_finish();
  end
  initial begin
    #2ms;
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
`default_nettype wire
